// [logic/smc_ctrl.sv]
// Standby mode controller: deep halt with key and voltage release, warm-up,
// core halt and timing-generator halt, reached over an Avalon-MM slave.
// Assumes the interrupt controller runs on clk; pins and detector are async.
//
// Contract
// (R01) Key wakeup pin at selectable high or low level releases deep halt.
// (R02) Once warm-up starts, deep halt is never re-entered from key level.
// (R03) Voltage-detect reset mode: supply below threshold leaves deep halt, asserts reset.
// (R04) Supply recovery drops that reset, runs warm-up, then single-clock fast run.
// (R05) Recovery within one machine cycle of deep-halt request does not release.
// (R06) Release restarts oscillators, then holds everything stopped during warm-up.
// (R07) After warm-up resume next instruction and clear prescaler and divider.
// (R08) Oscillators restarted follow the run mode held at deep-halt entry.
// (R09) Returning to dual-clock fast run clocks the warm-up divider from fast oscillator.
// (R10) Core halt stops CPU and watchdog, peripherals run, state retained.
// (R11) In core or timing halt the program counter is held.
// (R12) Software clears master enable, sets wake enables, then writes nap bit.
// (R13) Release condition already true at request keeps nap bit clear, no halt.
// (R14) Watchdog interrupt just before halt entry is serviced and halt skipped.
// (R15) Core-halt release clears nap bit and returns to preceding run mode.
// (R16) Pin, power-on or voltage reset releases any halt, then warm-up, fast run.
// (R17) Master enable 0: enabled latch releases core halt, no service, next instruction.
// (R18) Master enable 1: enabled latch releases core halt and interrupt is serviced.
// (R19) Timing halt gates peripheral clocks except base timer, state retained.
// (R20) Software disables timers, then writes timing halt bit.
// (R21) Timing-halt release clears bit, returns, sets base timer latch if enabled.
// (R22) All three enables 0: falling source edge releases, next instruction.
// (R23) All three enables 1: falling source edge releases, then base timer service.
// (R24) Key pins and voltage detector are synchronised before use.
//
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module smc_ctrl
    import smc_pkg::*;
(
    input  wire logic        clk,               // System clock, 20 MHz.
    input  wire logic        reset,             // Pin or power-on reset, sync.
    input  wire logic [4:0]  address,           // Avalon byte address.
    input  wire logic        read,              // Avalon read request.
    input  wire logic        write,             // Avalon write request.
    input  wire logic [31:0] writedata,         // Avalon write data.
    output logic      [31:0] readdata,          // Avalon read data.
    output logic             waitrequest,       // Avalon wait request.
    input  wire logic [3:0]  key_pins,          // Key wakeup pins, async.
    input  wire logic        vdet_low,          // Supply below threshold, async.
    input  wire logic [7:0]  bt_src,            // Base timer source clocks, async.
    input  wire smc_irq_type irq_in,            // Interrupt controller state.
    output smc_ctrl_type     ctrl,              // Clock and core controls.
    output logic             prescaler_clear,   // Prescaler and divider clear pulse.
    output logic             resume_next,       // Resume at next instruction pulse.
    output logic             irq_service,       // Service pending interrupt pulse.
    output logic             base_timer_irq_set // Base timer latch set pulse.
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [3:0] key_m_r, key_s_r;
    logic       vdet_m_r, vdet_s_r;
    logic [7:0] bt_m_r, bt_s_r;
    logic       bt_prev_r;

    always_ff @(posedge clk) begin
        key_m_r  <= key_pins;  // R24
        key_s_r  <= key_m_r;
        vdet_m_r <= vdet_low;  // R24
        vdet_s_r <= vdet_m_r;
        bt_m_r   <= bt_src;
        bt_s_r   <= bt_m_r;
    end

    // ----------------------------------------------------------------
    // Registers and bus slave
    // ----------------------------------------------------------------
    logic [7:0]    ctrl_one_r, ctrl_two_r;
    logic [3:0]    bt_ctrl_r;
    logic [15:0]   warm_load_r;
    logic          ack_r;
    smc_state_type state_r, state_nxt;
    smc_run_type   run_r;

    wire acc    = (read | write) & ack_r;
    wire wr_one = acc & write & (address == OFS_CTRL_ONE);
    wire wr_two = acc & write & (address == OFS_CTRL_TWO);

    assign waitrequest = (read | write) & ~ack_r;

    function automatic logic [31:0] reg_read(input logic [4:0] a);
        case (a)
            OFS_CTRL_ONE: reg_read = {24'h00_0000, ctrl_one_r};
            OFS_CTRL_TWO: reg_read = {24'h00_0000, ctrl_two_r};
            OFS_BT_CTRL:  reg_read = {28'h000_0000, bt_ctrl_r};
            OFS_WARM:     reg_read = {16'h0000, warm_load_r};
            OFS_STATUS:   reg_read = {19'h0_0000, state_r, run_r, ctrl};
            default:      reg_read = 32'h0000_0000;
        endcase
    endfunction

    always_ff @(posedge clk) begin
        if (reset) begin
            ack_r    <= 1'b0;
            readdata <= 32'h0000_0000;
        end else begin
            ack_r <= (read | write) & ~ack_r;
            if (read & ~ack_r) begin
                readdata <= reg_read(address);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            bt_ctrl_r   <= BT_CTRL_RST;
            warm_load_r <= WARM_RST;
        end else if (acc & write) begin
            if (address == OFS_BT_CTRL) begin
                bt_ctrl_r <= writedata[3:0];
            end
            if (address == OFS_WARM) begin
                warm_load_r <= writedata[15:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Release conditions
    // ----------------------------------------------------------------
    logic [$clog2(MCYC_CYC+1)-1:0] mc_cnt_r, guard_r;
    logic [15:0] warm_cnt_r;

    wire mc_tick   = (mc_cnt_r == '0);
    wire [3:0] key_en = ctrl_one_r[C1_KEY_LSB +: 4];
    wire key_hit   = |(key_en & (ctrl_one_r[C1_KEY_HIGH] ? key_s_r : ~key_s_r)); // R01
    wire vdet_hit  = ctrl_one_r[C1_VDET_RST] & vdet_s_r;
    wire bt_now    = bt_s_r[bt_ctrl_r[BT_SEL_LSB +: 3]];
    wire bt_fall   = bt_prev_r & ~bt_now;
    wire pending   = |(irq_in.irq_latch & irq_in.irq_source_enable);
    wire bt_all    = irq_in.master_irq_enable & bt_ctrl_r[BT_EN]
                   & irq_in.irq_source_enable[BT_IRQ_IDX];
    wire nap_req   = wr_two & writedata[C2_NAP];
    wire tg_req    = wr_two & writedata[C2_TG_HALT];
    wire deep_req  = wr_one & writedata[C1_DEEP_REQ];
    wire nap_skip  = pending | irq_in.wdt_irq;
    wire warm_done = (state_r == ST_WARM) & mc_tick & (warm_cnt_r == 16'h0000);

    always_ff @(posedge clk) begin
        if (reset) begin
            bt_prev_r <= 1'b0;
            mc_cnt_r  <= '0;
        end else begin
            bt_prev_r <= bt_now;
            mc_cnt_r  <= mc_tick ? ($bits(mc_cnt_r))'(MCYC_CYC - 1) : mc_cnt_r - 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Mode state machine
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (deep_req) begin
                    state_nxt = ST_DEEP;
                end else if (nap_req & ~nap_skip) begin
                    state_nxt = ST_CORE;
                end else if (tg_req & ~irq_in.wdt_irq) begin // R14
                    state_nxt = ST_TGH;
                end
            end
            ST_DEEP: begin
                if (key_hit) begin
                    state_nxt = ST_WARM;
                end
            end
            ST_WARM: begin
                if (warm_done) begin
                    state_nxt = ST_RUN; // R02
                end
            end
            ST_CORE: begin
                if (pending) begin
                    state_nxt = ST_RUN; // R15
                end
            end
            ST_TGH: begin
                if (bt_fall) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_VRST: begin
                if (!vdet_hit) begin
                    state_nxt = ST_WARM; // R04
                end
            end
            default: state_nxt = ST_RUN;
        endcase
        if (vdet_hit && !(state_r == ST_DEEP && guard_r != '0)) begin
            state_nxt = ST_VRST; // R03 R05 R16
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= ST_WARM; // R16
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            guard_r <= '0;
        end else if (state_r == ST_RUN && state_nxt == ST_DEEP) begin
            guard_r <= ($bits(guard_r))'(MCYC_CYC); // R05
        end else if (guard_r != '0) begin
            guard_r <= guard_r - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            run_r <= RUN_FAST_SINGLE;
        end else if (state_nxt == ST_VRST) begin
            run_r <= RUN_FAST_SINGLE; // R04
        end else if (state_r == ST_RUN) begin
            run_r <= smc_run_type'(ctrl_two_r[C2_RUN_LSB +: 2]);
        end
    end

    always_ff @(posedge clk) begin
        if (reset || state_r != ST_WARM) begin
            warm_cnt_r <= warm_load_r; // R06
        end else if (mc_tick && warm_cnt_r != 16'h0000) begin
            warm_cnt_r <= warm_cnt_r - 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Control bits: request bits are cleared by hardware on release
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_one_r <= CTRL_ONE_RST;
        end else if (wr_one) begin
            ctrl_one_r <= writedata[7:0];
        end else if (state_r == ST_WARM && state_nxt == ST_RUN) begin
            ctrl_one_r[C1_DEEP_REQ] <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_two_r <= CTRL_TWO_RST;
        end else if (wr_two) begin
            ctrl_two_r <= writedata[7:0];
            ctrl_two_r[C2_NAP] <= writedata[C2_NAP] & ~nap_skip & ~deep_req; // R13 R14
            ctrl_two_r[C2_TG_HALT] <= writedata[C2_TG_HALT] & ~irq_in.wdt_irq
                                    & ~(writedata[C2_NAP] & ~nap_skip) & ~deep_req;
        end else if (state_nxt == ST_VRST) begin
            ctrl_two_r <= CTRL_TWO_RST; // R04
        end else if (state_nxt != state_r && state_nxt != ST_CORE && state_nxt != ST_TGH) begin
            ctrl_two_r[C2_NAP]     <= 1'b0; // R15
            ctrl_two_r[C2_TG_HALT] <= 1'b0; // R21
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    function automatic smc_ctrl_type ctrl_of(input smc_state_type s, input smc_run_type r);
        ctrl_of = '0;
        case (s)
            ST_RUN, ST_CORE, ST_TGH, ST_WARM: begin
                ctrl_of.osc_fast_en   = (r != RUN_LOW_ONLY); // R08
                ctrl_of.osc_low_en    = (r != RUN_FAST_SINGLE);
                ctrl_of.warm_fast_sel = (r != RUN_LOW_ONLY); // R09
            end
            default: ctrl_of = '0;
        endcase
        ctrl_of.cpu_stop    = (s != ST_RUN); // R06 R10
        ctrl_of.wdt_stop    = (s != ST_RUN);
        ctrl_of.periph_gate = (s == ST_TGH) | (s == ST_DEEP) | (s == ST_WARM); // R19
        ctrl_of.pc_hold     = (s == ST_CORE) | (s == ST_TGH); // R11
        ctrl_of.vdet_reset  = (s == ST_VRST); // R03
    endfunction

    smc_run_type run_nxt;
    assign run_nxt = (state_nxt == ST_VRST) ? RUN_FAST_SINGLE : run_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl               <= '0;
            prescaler_clear    <= 1'b0;
            resume_next        <= 1'b0;
            irq_service        <= 1'b0;
            base_timer_irq_set <= 1'b0;
        end else begin
            ctrl            <= ctrl_of(state_nxt, run_nxt);
            prescaler_clear <= warm_done & ~vdet_hit; // R07
            resume_next     <= (warm_done & ~vdet_hit)
                             | (state_r == ST_CORE & pending & ~irq_in.master_irq_enable
                                & ~vdet_hit) // R17
                             | (state_r == ST_TGH & bt_fall & ~bt_all & ~vdet_hit); // R22
            irq_service     <= (state_r == ST_CORE & pending & irq_in.master_irq_enable
                                & ~vdet_hit) // R18
                             | (state_r == ST_TGH & bt_fall & bt_all & ~vdet_hit); // R23
            base_timer_irq_set <= state_r == ST_TGH & bt_fall & bt_ctrl_r[BT_EN]
                                & ~vdet_hit; // R21
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence warm_leave_s;
        state_r == ST_WARM ##1 state_r == ST_RUN;
    endsequence

    sequence core_wake_s;
        state_r == ST_CORE && pending && !vdet_hit;
    endsequence

    sequence tg_wake_s;
        state_r == ST_TGH && bt_fall && !vdet_hit;
    endsequence

    warm_no_deep_a: assert property (state_r == ST_WARM |=> state_r != ST_DEEP) // R02
        else $error("warm-up fell back into deep halt");

    vdet_reset_a: assert property ((vdet_hit && state_r != ST_DEEP) |=> ctrl.vdet_reset) // R03
        else $error("voltage reset not asserted");

    vdet_exit_a: assert property ((state_r == ST_VRST && !vdet_hit)
        |=> state_r == ST_WARM && run_r == RUN_FAST_SINGLE && !ctrl.vdet_reset) // R04
        else $error("voltage reset exit wrong");

    deep_guard_a: assert property ((state_r == ST_DEEP && guard_r != '0)
        |=> state_r != ST_VRST) // R05
        else $error("deep halt left during guard");

    warm_end_a: assert property (warm_leave_s |-> prescaler_clear && resume_next
        && !ctrl.cpu_stop) // R07
        else $error("warm-up end pulses missing");

    osc_mode_a: assert property (state_r == ST_WARM && !$past(reset) |-> ctrl.cpu_stop
        && ctrl.osc_fast_en == (run_r != RUN_LOW_ONLY)
        && ctrl.osc_low_en == (run_r != RUN_FAST_SINGLE)) // R08
        else $error("oscillator enables wrong");

    core_halt_a: assert property (state_r == ST_CORE |-> ctrl.cpu_stop && ctrl.wdt_stop
        && !ctrl.periph_gate && ctrl.pc_hold) // R10
        else $error("core halt controls wrong");

    nap_skip_a: assert property ((state_r == ST_RUN && nap_req && nap_skip && !deep_req)
        |=> !ctrl_two_r[C2_NAP] && state_r != ST_CORE) // R13
        else $error("core halt entered despite wake");

    core_wake_a: assert property (core_wake_s |=> state_r == ST_RUN
        && !ctrl_two_r[C2_NAP] && irq_service == $past(irq_in.master_irq_enable)) // R15
        else $error("core halt release wrong");

    tg_wake_a: assert property (tg_wake_s
        |=> state_r == ST_RUN && !ctrl_two_r[C2_TG_HALT]
        && base_timer_irq_set == $past(bt_ctrl_r[BT_EN])) // R21
        else $error("timing halt release wrong");

    tg_mode_a: assert property (tg_wake_s |=> resume_next != irq_service
        && irq_service == $past(bt_all)) // R22 R23
        else $error("timing halt release mode wrong");

endmodule
`default_nettype wire

// [logic/smc_pkg.sv]
// Constants, register map and carrier types of the standby mode controller.
// Assumes one 20 MHz system clock and an Avalon-MM slave register port.
package smc_pkg;

    localparam int CLK_NS   = 50;
    localparam int MCYC_NS  = 200;
    localparam int MCYC_CYC = (MCYC_NS + CLK_NS - 1) / CLK_NS;

    localparam logic [4:0] OFS_CTRL_ONE = 5'h00;
    localparam logic [4:0] OFS_CTRL_TWO = 5'h04;
    localparam logic [4:0] OFS_BT_CTRL  = 5'h08;
    localparam logic [4:0] OFS_WARM     = 5'h0C;
    localparam logic [4:0] OFS_STATUS   = 5'h10;

    localparam int C1_DEEP_REQ = 0;
    localparam int C1_KEY_HIGH = 1;
    localparam int C1_VDET_RST = 2;
    localparam int C1_KEY_LSB  = 4;
    localparam int C2_NAP      = 0;
    localparam int C2_TG_HALT  = 1;
    localparam int C2_RUN_LSB  = 2;
    localparam int BT_EN       = 0;
    localparam int BT_SEL_LSB  = 1;
    localparam int BT_IRQ_IDX  = 5;

    localparam logic [7:0]  CTRL_ONE_RST = 8'h00;
    localparam logic [7:0]  CTRL_TWO_RST = 8'h00;
    localparam logic [3:0]  BT_CTRL_RST  = 4'h0;
    localparam logic [15:0] WARM_RST     = 16'h0010;

    typedef enum logic [2:0] {
        ST_RUN  = 3'b000,
        ST_DEEP = 3'b001,
        ST_WARM = 3'b010,
        ST_CORE = 3'b011,
        ST_TGH  = 3'b100,
        ST_VRST = 3'b101
    } smc_state_type;

    typedef enum logic [1:0] {
        RUN_FAST_SINGLE = 2'b00,
        RUN_FAST_DUAL   = 2'b01,
        RUN_LOW_ONLY    = 2'b10
    } smc_run_type;

    typedef struct packed {
        logic cpu_stop;
        logic wdt_stop;
        logic periph_gate;
        logic osc_fast_en;
        logic osc_low_en;
        logic warm_fast_sel;
        logic pc_hold;
        logic vdet_reset;
    } smc_ctrl_type;

    typedef struct packed {
        logic       master_irq_enable;
        logic [7:0] irq_source_enable;
        logic [7:0] irq_latch;
        logic       wdt_irq;
    } smc_irq_type;

endpackage

// [verification/smc_ctrl_test.sv]
// Self-checking bench of the standby mode controller.
// Assumes the far-side model supplies interrupt state and timer sources.
`timescale 1ns/1ns
`default_nettype none
module smc_ctrl_test;
    import smc_pkg::*;
    logic clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0, waitrequest, vdet_low = 1'b0;
    logic [4:0]  address = 5'h00;
    logic [31:0] writedata = 32'h0000_0000, readdata;
    logic [3:0]  key_pins = 4'h0, pv;
    logic [7:0]  bt_src, src_en = 8'h00, set_req = 8'h00, clr_req = 8'h00;
    logic        master = 1'b0, wdt = 1'b0, bt_run = 1'b0;
    logic        prescaler_clear, resume_next, irq_service, base_timer_irq_set;
    smc_irq_type  irq_in;
    smc_ctrl_type ctrl;
    int failures = 0, samples_checked = 0, cnt [4] = '{0, 0, 0, 0};

    smc_ctrl i_dut (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .key_pins(key_pins), .vdet_low(vdet_low), .bt_src(bt_src), .irq_in(irq_in),
        .ctrl(ctrl), .prescaler_clear(prescaler_clear), .resume_next(resume_next),
        .irq_service(irq_service), .base_timer_irq_set(base_timer_irq_set));
    smc_far_model i_far (.clk(clk), .reset(reset), .master(master), .src_en(src_en),
        .set_req(set_req), .clr_req(clr_req), .wdt(wdt), .bt_run(bt_run),
        .irq_service(irq_service), .base_timer_irq_set(base_timer_irq_set),
        .irq_in(irq_in), .bt_src(bt_src));

    always #25 clk = ~clk;
    assign pv = {base_timer_irq_set, irq_service, prescaler_clear, resume_next};
    always @(posedge clk) for (int i = 0; i < 4; i++) if (pv[i] === 1'b1) cnt[i] <= cnt[i] + 1;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        read <= ~wr;
        write <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        q = readdata;
        if (n >= 20) failures++;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_pulse(input int k, input int lim);
        int s;
        int n;
        s = cnt[k];
        n = 0;
        while (cnt[k] == s && n < lim) begin
            @(posedge clk);
            n++;
        end
        check(32'(cnt[k] != s), 32'h0000_0001);
    endtask

    task automatic do_reset(input int n);
        reset <= 1'b1;
        repeat (n) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        @(posedge clk);
        check(32'({ctrl.cpu_stop, ctrl.osc_fast_en, ctrl.warm_fast_sel}), 32'h0000_0007);
        wait_pulse(0, 200);
    endtask

    function automatic logic [2:0] osc_exp(input int m);
        return {m != 2, m != 0, m != 2};
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    localparam logic [4:0]  RA [5] = '{OFS_CTRL_ONE, OFS_CTRL_TWO, OFS_BT_CTRL, OFS_WARM, 5'h14};
    localparam logic [31:0] RV [5] = '{32'(CTRL_ONE_RST), 32'(CTRL_TWO_RST),
                                       32'(BT_CTRL_RST), 32'(WARM_RST), 32'h0000_0000};
    localparam logic [2:0]  TGV [3] = '{3'b000, 3'b111, 3'b001};
    initial begin
        logic [31:0] q;
        int          k;
        int          b;
        logic [3:0]  en4;
        void'($urandom(16632));
        do_reset(8);
        bus(1'b1, 5'h14, 32'hFFFF_FFFF, q);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, RA[i], 32'h0000_0000, q);
            check(q, RV[i]);
        end
        $display("done: reset values");
        for (int m = 0; m < 3; m++) for (int lv = 0; lv < 2; lv++) begin
            k = $urandom_range(3, 0);
            en4 = 4'(1 << k) | 4'($urandom);
            key_pins <= lv ? 4'h0 : 4'hF;
            bus(1'b1, OFS_WARM, 32'($urandom_range(5, 3)), q);
            bus(1'b1, OFS_CTRL_TWO, 32'(m) << C2_RUN_LSB, q);
            bus(1'b1, OFS_CTRL_ONE, {24'h00_0000, en4, 2'b00, 1'(lv), 1'b1}, q);
            repeat (6) @(posedge clk);
            bus(1'b0, OFS_STATUS, 32'h0000_0000, q);
            check(32'({q[12:10], q[4:3]}), 32'h0000_0004);
            key_pins[k] <= 1'(lv);
            repeat (5) @(posedge clk);
            key_pins <= lv ? 4'h0 : 4'hF;
            b = cnt[1];
            bus(1'b0, OFS_STATUS, 32'h0000_0000, q);
            check(32'({q[12:10], q[7:2]}), {23'h00_0000, 3'h2, 3'b111, osc_exp(m)});
            wait_pulse(0, 200);
            check(32'(cnt[1] - b), 32'h0000_0001);
            bus(1'b0, OFS_STATUS, 32'h0000_0000, q);
            check(32'({q[12:10], q[9:8]}), 32'(m));
        end
        $display("done: key wakeup");
        bus(1'b1, OFS_CTRL_TWO, 32'(RUN_FAST_DUAL) << C2_RUN_LSB, q);
        fork
            bus(1'b1, OFS_CTRL_ONE, 32'h0000_0005, q);
            begin
                @(posedge clk);
                vdet_low <= 1'b1;
                @(posedge clk);
                vdet_low <= 1'b0;
            end
        join
        repeat (8) @(posedge clk);
        bus(1'b0, OFS_STATUS, 32'h0000_0000, q);
        check(32'(q[12:10]), 32'h0000_0001);
        vdet_low <= 1'b1;
        k = 0;
        while (ctrl.vdet_reset !== 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
        end
        check(32'(ctrl.vdet_reset), 32'h0000_0001);
        vdet_low <= 1'b0;
        wait_pulse(0, 300);
        bus(1'b0, OFS_STATUS, 32'h0000_0000, q);
        check(32'({q[12:10], q[9:8], q[0]}), 32'h0000_0000);
        bus(1'b1, OFS_CTRL_ONE, 32'h0000_0000, q);
        $display("done: voltage release");
        for (int i = 0; i < 4; i++) begin
            k = $urandom_range(7, 0);
            master <= (i == 1);
            src_en <= 8'(1 << k);
            set_req <= (i == 2) ? 8'(1 << k) : 8'h00;
            wdt <= (i == 3);
            @(posedge clk);
            set_req <= 8'h00;
            bus(1'b1, OFS_CTRL_TWO, 32'h0000_0005, q);
            bus(1'b0, OFS_STATUS, 32'h0000_0000, q);
            if (i >= 2) begin
                check(32'(q[12:10]), 32'h0000_0000);
            end else begin
                check(32'({q[12:10], q[7:5], q[1]}), 32'h0000_003D);
                set_req <= 8'(1 << k);
                @(posedge clk);
                set_req <= 8'h00;
                wait_pulse((i == 1) ? 2 : 0, 20);
            end
            bus(1'b0, OFS_CTRL_TWO, 32'h0000_0000, q);
            check(32'(q[3:0]), 32'h0000_0004);
            clr_req <= 8'hFF;
            wdt <= 1'b0;
            @(posedge clk);
            clr_req <= 8'h00;
        end
        $display("done: core halt");
        for (int i = 0; i < 3; i++) begin
            master <= TGV[i][2];
            src_en <= {2'b00, TGV[i][1], 5'h00};
            bus(1'b1, OFS_BT_CTRL, (32'($urandom_range(7, 0)) << BT_SEL_LSB) | 32'(TGV[i][0]), q);
            b = cnt[3];
            bus(1'b1, OFS_CTRL_TWO, 32'h0000_0002, q);
            bus(1'b0, OFS_STATUS, 32'h0000_0000, q);
            check(32'({q[12:10], q[5], q[1]}), 32'h0000_0013);
            bt_run <= 1'b1;
            wait_pulse((i == 1) ? 2 : 0, 700);
            bt_run <= 1'b0;
            check(32'(cnt[3] - b), 32'(TGV[i][0]));
            bus(1'b0, OFS_CTRL_TWO, 32'h0000_0000, q);
            check(32'(q[1]), 32'h0000_0000);
            clr_req <= 8'hFF;
            @(posedge clk);
            clr_req <= 8'h00;
        end
        $display("done: timing halt");
        src_en <= 8'h01;
        master <= 1'b0;
        bus(1'b1, OFS_CTRL_TWO, 32'h0000_0005, q);
        do_reset(3);
        bus(1'b0, OFS_STATUS, 32'h0000_0000, q);
        check(32'({q[12:10], q[9:8]}), 32'h0000_0000);
        $display("done: reset from halt");
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        close_out();
    end
endmodule
`default_nettype wire

// [verification/smc_far_model.sv]
// Far-side model: interrupt latches and base timer source clocks.
// Assumes the bench acts as software and pins and shares clk with the design.
`timescale 1ns/1ns
`default_nettype none
module smc_far_model
    import smc_pkg::*;
(
    input  wire logic       clk,                // System clock.
    input  wire logic       reset,              // Sync reset.
    input  wire logic       master,             // Master enable from software.
    input  wire logic [7:0] src_en,             // Source enables from software.
    input  wire logic [7:0] set_req,            // Interrupt source requests.
    input  wire logic [7:0] clr_req,            // Software latch clears.
    input  wire logic       wdt,                // Watchdog interrupt.
    input  wire logic       bt_run,             // Sources toggle while high.
    input  wire logic       irq_service,        // Design services an interrupt.
    input  wire logic       base_timer_irq_set, // Design sets base timer latch.
    output smc_irq_type     irq_in,             // Interrupt state to the design.
    output logic [7:0]      bt_src              // Base timer source clocks.
);
    logic [7:0]  latch_r;
    logic [8:0]  div_r;
    logic [7:0]  pend;
    logic [7:0]  take;

    // Servicing clears the lowest pending enabled latch only.
    always_comb pend = latch_r & src_en;
    always_comb take = irq_service ? (pend & ~(pend - 8'h01)) : 8'h00;
    always_comb irq_in = {master, src_en, latch_r, wdt};
    always_comb bt_src = bt_run ? div_r[8:1] : 8'hFF;

    always_ff @(posedge clk) begin
        if (reset) begin
            latch_r <= 8'h00;
        end else begin
            latch_r <= (latch_r | set_req | ({7'h00, base_timer_irq_set} << BT_IRQ_IDX))
                       & ~clr_req & ~take;
        end
    end

    always_ff @(posedge clk) begin
        div_r <= reset ? 9'h000 : div_r + 9'h001;
    end
endmodule
`default_nettype wire
